//--- src/lcd_timing_pkg.sv
// constants shared by the panel clock and power timing core
package lcd_timing_pkg;

  // ==========================================================
  // system clock and shift clock limits
  localparam int          SYS_CLK_PERIOD_NS = 5;
  localparam int          SHIFT_MAX_MHZ     = 15;
  localparam logic [4:0]  SHIFT_DIV_00      = 5'h04;
  localparam logic [4:0]  SHIFT_DIV_01      = 5'h08;
  localparam logic [4:0]  SHIFT_DIV_10      = 5'h10;
  localparam logic [4:0]  SHIFT_DIV_RSVD    = 5'h10;
  localparam logic [1:0]  STRAP_DIV4        = 2'h0;
  localparam logic [1:0]  STRAP_DIV8        = 2'h1;
  localparam logic [1:0]  STRAP_DIV16       = 2'h2;

  // ==========================================================
  // memory map
  localparam int          MEM_BYTES         = 32768;
  localparam int          MEM_AW            = 15;
  localparam logic [14:0] REG_BASE          = 15'h7fc0;
  localparam logic [5:0]  REG_PSAVE_IDX     = 6'h08;
  localparam logic [5:0]  REG_DISP_EN_IDX   = 6'h09;
  localparam logic        PSAVE_RST         = 1'h0;
  localparam logic        DISP_EN_RST       = 1'h0;

  // ==========================================================
  // command codes
  localparam logic [7:0]  CMD_DISPLAY_OFF   = 8'h58;

  // ==========================================================
  // panel line blanking, in shift periods
  localparam logic [2:0]  BLANK_LINE_SLOT   = 3'h0;
  localparam logic [2:0]  BLANK_ROW_SLOT    = 3'h1;
  localparam logic [2:0]  BLANK_LAST_SLOT   = 3'h5;

  typedef enum logic [0:0] {
    LCD_ACTIVE = 1'b0,
    LCD_BLANK  = 1'b1
  } lcd_panel_e;

endpackage

//--- src/lcd_sync3.sv
// three-stage pin synchroniser with agreement filter and raw delay tap
module lcd_sync3 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      dly,
  output logic [W-1:0]      q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: take a change once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          q[i] <= RST_VAL[i];
        end else if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign dly = s3_q;

endmodule

//--- src/lcd_mem.sv
// embedded byte memory, one read/write port and one read port
module lcd_mem #(
  parameter int DEPTH = 32768,
  parameter int AW    = 15
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          a_en,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [7:0]    a_wdata,
  output logic [7:0]         a_rdata,
  input  wire logic [AW-1:0] b_addr,
  output logic [7:0]         b_rdata
);

  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      a_rdata <= 8'h00;
    end else if (a_en && !a_we) begin
      a_rdata <= mem[a_addr];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      b_rdata <= 8'h00;
    end else begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule

//--- src/lcd_timing_top.sv
// panel shift clock, panel strobes, power-down sequencing and host bus
module lcd_timing_top #(
  parameter int NIBBLES_PER_LINE = 80,
  parameter int LINES_PER_FRAME  = 240
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       host_clk,
  input  wire logic [1:0] shift_rate_strap,
  input  wire logic       indirect_mode,
  input  wire logic       host_cs_n,
  input  wire logic       host_rd_n,
  input  wire logic       host_wr_n,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0] host_data_in,
  output logic [7:0]      host_data_out,
  output logic            host_data_oe_n,
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] cmd_code,
  output logic            pixel_shift_clock,
  output logic            line_pulse,
  output logic            row_scan_clock,
  output logic            frame_pulse,
  output logic [3:0]      panel_nibble_data,
  output logic            panel_power_down_out,
  output logic            display_enabled,
  output logic            power_saving,
  output logic            shift_rate_unsupported
);

  // ==========================================================
  // declarations
  logic [29:0]                   pin_dly;
  logic [29:0]                   pin_q;
  logic [15:0]                   bus_addr;
  logic [7:0]                    bus_data;
  logic [1:0]                    strap_s;
  logic                          indirect_s;
  logic                          cs_n_s;
  logic                          rd_n_s;
  logic                          wr_n_s;
  logic                          rd_n_prev_q;
  logic                          wr_n_prev_q;
  logic                          rd_start;
  logic                          rd_end;
  logic                          wr_end;
  logic                          wr_cs_q;
  logic [15:0]                   wr_addr_q;
  logic [7:0]                    wr_data_q;
  logic                          mem_en;
  logic                          mem_we;
  logic [lcd_timing_pkg::MEM_AW-1:0] mem_addr;
  logic [lcd_timing_pkg::MEM_AW-1:0] wr_mem_addr;
  logic [lcd_timing_pkg::MEM_AW-1:0] rd_mem_addr;
  logic [7:0]                    pan_rdata;
  logic [lcd_timing_pkg::MEM_AW-1:0] pan_addr_q;
  logic                          off_tgl_q;
  logic                          off_tgl_s;
  logic                          off_seen_q;
  logic                          off_evt;
  logic                          ps_q;
  logic                          de_q;
  logic                          pd_q;
  logic [1:0]                    ps_frames_q;
  logic [4:0]                    div_q;
  logic [3:0]                    ph_q;
  logic [3:0]                    ph_d;
  logic                          tick;
  lcd_timing_pkg::lcd_panel_e    st_q;
  logic [15:0]                   col_q;
  logic [15:0]                   row_q;
  logic [2:0]                    blk_q;
  logic                          nib_hi_q;
  logic                          frame_end;

  // ==========================================================
  // pin synchronisers
  lcd_sync3 #(
    .W       (30),
    .RST_VAL (30'h00000007)
  ) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({host_addr, host_data_in, shift_rate_strap, indirect_mode,
             host_cs_n, host_rd_n, host_wr_n}),
    .dly   (pin_dly),
    .q     (pin_q)
  );

  assign bus_addr   = pin_dly[29:14];
  assign bus_data   = pin_dly[13:6];
  assign strap_s    = pin_q[5:4];
  assign indirect_s = pin_q[3];
  assign cs_n_s     = pin_q[2];
  assign rd_n_s     = pin_q[1];
  assign wr_n_s     = pin_q[0];

  // ==========================================================
  // command port on the link clock
  always_ff @(posedge host_clk or posedge reset) begin
    if (reset) begin
      off_tgl_q <= 1'b0;
    end else if (cmd_strobe && cmd_code == lcd_timing_pkg::CMD_DISPLAY_OFF) begin
      off_tgl_q <= ~off_tgl_q;
    end
  end

  lcd_sync3 #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_cmd_sync (
    .clk   (clk),
    .reset (reset),
    .d     (off_tgl_q),
    .dly   (),
    .q     (off_tgl_s)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      off_seen_q <= 1'b0;
    end else begin
      off_seen_q <= off_tgl_s;
    end
  end

  assign off_evt = (off_tgl_s != off_seen_q) && indirect_s;

  // ==========================================================
  // host strobes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
    end else begin
      rd_n_prev_q <= rd_n_s;
      wr_n_prev_q <= wr_n_s;
    end
  end

  assign rd_start = rd_n_prev_q && !rd_n_s && !cs_n_s;
  assign rd_end   = !rd_n_prev_q && rd_n_s;
  assign wr_end   = !wr_n_prev_q && wr_n_s && wr_cs_q;

  // latch write data while the strobe is low, commit at its end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_cs_q   <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 8'h00;
    end else if (!wr_n_s) begin
      wr_cs_q   <= !cs_n_s;
      wr_addr_q <= bus_addr;
      wr_data_q <= bus_data;
    end else if (wr_end) begin
      wr_cs_q   <= 1'b0;
    end
  end

  // register window sits at the top of the shared memory
  assign wr_mem_addr = wr_addr_q[15] ? (lcd_timing_pkg::REG_BASE | {9'h000, wr_addr_q[5:0]})
                                     : wr_addr_q[14:0];
  assign rd_mem_addr = bus_addr[15] ? (lcd_timing_pkg::REG_BASE | {9'h000, bus_addr[5:0]})
                                    : bus_addr[14:0];
  assign mem_en      = wr_end || rd_start;
  assign mem_we      = wr_end;
  assign mem_addr    = wr_end ? wr_mem_addr : rd_mem_addr;

  // read data lands one edge after the strobe is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_data_oe_n <= 1'b1;
    end else if (rd_start) begin
      host_data_oe_n <= 1'b0;
    end else if (rd_end) begin
      host_data_oe_n <= 1'b1;
    end
  end

  lcd_mem #(
    .DEPTH (lcd_timing_pkg::MEM_BYTES),
    .AW    (lcd_timing_pkg::MEM_AW)
  ) u_mem (
    .clk     (clk),
    .reset   (reset),
    .a_en    (mem_en),
    .a_we    (mem_we),
    .a_addr  (mem_addr),
    .a_wdata (wr_data_q),
    .a_rdata (host_data_out),
    .b_addr  (pan_addr_q),
    .b_rdata (pan_rdata)
  );

  // ==========================================================
  // power save and display enable bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ps_q <= lcd_timing_pkg::PSAVE_RST;
      de_q <= lcd_timing_pkg::DISP_EN_RST;
    end else begin
      if (wr_end && wr_addr_q[15] && wr_addr_q[5:0] == lcd_timing_pkg::REG_PSAVE_IDX) begin
        ps_q <= wr_data_q[0];
      end
      if (off_evt) begin
        de_q <= 1'b0;
      end else if (wr_end && wr_addr_q[15]
                   && wr_addr_q[5:0] == lcd_timing_pkg::REG_DISP_EN_IDX) begin
        de_q <= wr_data_q[0];
      end
    end
  end

  // frames seen since power save was entered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ps_frames_q <= 2'h0;
    end else if (!ps_q) begin
      ps_frames_q <= 2'h0;
    end else if (frame_end && ps_frames_q != 2'h3) begin
      ps_frames_q <= ps_frames_q + 2'h1;
    end
  end

  // panel power-down output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pd_q <= 1'b0;
    end else if (!de_q || off_evt) begin
      pd_q <= 1'b0;
    end else if (ps_q) begin
      if (frame_end) begin
        pd_q <= 1'b0;
      end
    end else begin
      pd_q <= 1'b1;
    end
  end

  assign panel_power_down_out = pd_q;
  assign display_enabled      = de_q;
  assign power_saving         = ps_q;

  // ==========================================================
  // shift divisor from the strap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= lcd_timing_pkg::SHIFT_DIV_RSVD;
    end else if (tick) begin
      case (strap_s)
        lcd_timing_pkg::STRAP_DIV4:  div_q <= lcd_timing_pkg::SHIFT_DIV_00;
        lcd_timing_pkg::STRAP_DIV8:  div_q <= lcd_timing_pkg::SHIFT_DIV_01;
        lcd_timing_pkg::STRAP_DIV16: div_q <= lcd_timing_pkg::SHIFT_DIV_10;
        default:                     div_q <= lcd_timing_pkg::SHIFT_DIV_RSVD;
      endcase
    end
  end

  // flag a divisor giving a shift clock above the limit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_rate_unsupported <= 1'b0;
    end else begin
      shift_rate_unsupported <= (32'(div_q) * lcd_timing_pkg::SYS_CLK_PERIOD_NS
                                 * lcd_timing_pkg::SHIFT_MAX_MHZ) < 1000;
    end
  end

  // ==========================================================
  // shift clock phase: high first half, low second half
  assign tick = ({1'b0, ph_q} == div_q - 5'h01);
  assign ph_d = tick ? 4'h0 : ph_q + 4'h1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_q              <= 4'h0;
      pixel_shift_clock <= 1'b0;
    end else begin
      ph_q              <= ph_d;
      pixel_shift_clock <= {1'b0, ph_d} < (div_q >> 1);
    end
  end

  // ==========================================================
  // line and frame sequencer, one step per shift period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q  <= lcd_timing_pkg::LCD_ACTIVE;
      col_q <= 16'h0000;
      row_q <= 16'h0000;
      blk_q <= 3'h0;
    end else if (tick) begin
      case (st_q)
        lcd_timing_pkg::LCD_ACTIVE: begin
          if (col_q == 16'(NIBBLES_PER_LINE - 1)) begin
            st_q  <= lcd_timing_pkg::LCD_BLANK;
            col_q <= 16'h0000;
            blk_q <= lcd_timing_pkg::BLANK_LINE_SLOT;
          end else begin
            col_q <= col_q + 16'h0001;
          end
        end
        lcd_timing_pkg::LCD_BLANK: begin
          if (blk_q == lcd_timing_pkg::BLANK_LAST_SLOT) begin
            st_q  <= lcd_timing_pkg::LCD_ACTIVE;
            row_q <= (row_q == 16'(LINES_PER_FRAME - 1)) ? 16'h0000 : row_q + 16'h0001;
          end else begin
            blk_q <= blk_q + 3'h1;
          end
        end
        default: st_q <= lcd_timing_pkg::LCD_ACTIVE;
      endcase
    end
  end

  assign frame_end = tick && frame_pulse && st_q == lcd_timing_pkg::LCD_BLANK
                     && blk_q == lcd_timing_pkg::BLANK_LAST_SLOT;

  // strobes change with the rising shift edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_pulse     <= 1'b0;
      row_scan_clock <= 1'b0;
      frame_pulse    <= 1'b0;
    end else if (tick) begin
      line_pulse     <= st_q == lcd_timing_pkg::LCD_ACTIVE
                        && col_q == 16'(NIBBLES_PER_LINE - 1);
      row_scan_clock <= st_q == lcd_timing_pkg::LCD_BLANK
                        && blk_q == lcd_timing_pkg::BLANK_LINE_SLOT;
      if (st_q == lcd_timing_pkg::LCD_ACTIVE && col_q == 16'(NIBBLES_PER_LINE - 1)
          && row_q == 16'(LINES_PER_FRAME - 1)) begin
        frame_pulse <= 1'b1;
      end else if (frame_end) begin
        frame_pulse <= 1'b0;
      end
    end
  end

  // nibble data: high nibble first, then low, then next byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      panel_nibble_data <= 4'h0;
      nib_hi_q          <= 1'b1;
      pan_addr_q        <= '0;
    end else if (tick) begin
      if (st_q == lcd_timing_pkg::LCD_ACTIVE) begin
        panel_nibble_data <= nib_hi_q ? pan_rdata[7:4] : pan_rdata[3:0];
        nib_hi_q          <= ~nib_hi_q;
        if (!nib_hi_q) begin
          pan_addr_q <= pan_addr_q + 15'h0001;
        end
      end else begin
        panel_nibble_data <= 4'h0;
        if (frame_end) begin
          pan_addr_q <= '0;
          nib_hi_q   <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_shift_div_four: assert property ($rose(pixel_shift_clock) && div_q == 5'h04
    |-> ##4 $rose(pixel_shift_clock)) else $error("shift period not 4 clocks");
  a_shift_div_eight: assert property ($rose(pixel_shift_clock) && div_q == 5'h08
    |-> pixel_shift_clock [*4] ##1 !pixel_shift_clock [*4] ##1 $rose(pixel_shift_clock))
    else $error("shift period not 8 clocks");
  a_strap_reserved: assert property (strap_s == 2'h3 && tick |-> ##1 div_q == 5'h10)
    else $error("reserved strap not slowest");
  a_psave_frames: assert property (ps_frames_q >= 2'h1 |-> !panel_power_down_out)
    else $error("power-down not low after a frame");
  a_cmd_off: assert property (off_evt |-> ##1 !panel_power_down_out)
    else $error("display-off command too slow");
  a_direct_off: assert property (!indirect_s && $fell(de_q)
    |-> ##[0:1] !panel_power_down_out) else $error("display disable too slow");
  a_display_on: assert property ($rose(de_q) && !ps_q |-> ##1 panel_power_down_out)
    else $error("display on too slow");
  a_read_data: assert property (rd_start |-> ##1 !host_data_oe_n)
    else $error("read data not driven in time");
  a_nibble_edge: assert property ($changed(panel_nibble_data)
    |-> $rose(pixel_shift_clock)) else $error("nibble changed off the rising edge");
  a_frame_after_line: assert property ($fell(line_pulse) && frame_pulse
    |-> frame_pulse [*8]) else $error("frame ended too early after line");
  a_frame_after_row: assert property ($fell(row_scan_clock) && frame_pulse
    |-> frame_pulse [*8] ##1 frame_pulse [*4]) else $error("frame ended too early after row");

endmodule

//--- test/lcd_panel_model.sv
// panel side model: shift period, nibble stability, strobe spacing
module lcd_panel_model (
  input  logic       clk,
  input  logic       reset,
  input  logic       pixel_shift_clock,
  input  logic       line_pulse,
  input  logic       row_scan_clock,
  input  logic       frame_pulse,
  input  logic [3:0] panel_nibble_data,
  output int         period,
  output int         lp_gap,
  output int         rs_gap,
  output int         n_unstable,
  output logic [3:0] first_nibble
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       pq, lq, rq, fq, seek_first;
  logic [3:0] nq;
  int         c, gl, gr;
  wire        rise = pixel_shift_clock && !pq;
  // ==========================================================
  // sampled on the settled half of each system clock
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      {pq, lq, rq, fq} <= 4'h0;
      nq <= 4'h0;
      c <= 0;
      gl <= 0;
      gr <= 0;
      period <= 0;
      lp_gap <= 0;
      rs_gap <= 0;
      n_unstable <= 0;
      seek_first <= 1'b0;
      first_nibble <= 4'h0;
    end else begin
      pq <= pixel_shift_clock;
      lq <= line_pulse;
      rq <= row_scan_clock;
      fq <= frame_pulse;
      nq <= panel_nibble_data;
      c <= rise ? 1 : c + 1;
      if (rise) period <= c;
      if (panel_nibble_data !== nq && !rise) n_unstable <= n_unstable + 1;
      gl <= (lq && !line_pulse) ? 0 : rise ? gl + 1 : gl;
      gr <= (rq && !row_scan_clock) ? 0 : rise ? gr + 1 : gr;
      if (rise && seek_first) begin
        first_nibble <= panel_nibble_data;
        seek_first <= 1'b0;
      end
      if (fq && !frame_pulse) begin
        seek_first <= 1'b1;
        lp_gap <= gl + 1;
        rs_gap <= gr + 1;
      end
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the panel timing core
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observed signals
  logic        clk = 0, reset = 1, host_clk = 0, hc_en = 0;
  logic [1:0]  shift_rate_strap = 2'h0;
  logic        indirect_mode = 0, cmd_strobe = 0;
  logic        host_cs_n = 1, host_rd_n = 1, host_wr_n = 1;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0]  host_data_in = 8'h00, cmd_code = 8'h00, host_data_out;
  logic        host_data_oe_n, pixel_shift_clock, line_pulse;
  logic        row_scan_clock, frame_pulse;
  logic [3:0]  panel_nibble_data, first_nibble;
  logic        panel_power_down_out, display_enabled, power_saving;
  logic        shift_rate_unsupported;
  int          period, lp_gap, rs_gap, n_unstable, n;
  int          n_mismatch = 0, total_checks = 0;
  logic [7:0]  mem_m [int];

  always #2.5 clk = ~clk;
  initial begin
    #33.3;
    forever #80 host_clk = hc_en ? ~host_clk : 1'b0;
  end

  lcd_timing_top #(.NIBBLES_PER_LINE(4), .LINES_PER_FRAME(3)) i_dut (
    .clk, .reset, .host_clk, .shift_rate_strap, .indirect_mode,
    .host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_data_in,
    .host_data_out, .host_data_oe_n, .cmd_strobe, .cmd_code,
    .pixel_shift_clock, .line_pulse, .row_scan_clock, .frame_pulse,
    .panel_nibble_data, .panel_power_down_out, .display_enabled,
    .power_saving, .shift_rate_unsupported
  );

  lcd_panel_model i_panel (
    .clk, .reset, .pixel_shift_clock, .line_pulse, .row_scan_clock,
    .frame_pulse, .panel_nibble_data, .period, .lp_gap, .rs_gap, .n_unstable,
    .first_nibble
  );

  // ==========================================================
  // compare and verdict
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic int exp_div(int s);
    return s == 0 ? 4 : s == 1 ? 8 : 16;
  endfunction

  // ==========================================================
  // host bus, command port and waits
  task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
    repeat (11) @(negedge clk);
    host_addr = a;
    host_data_in = d;
    host_cs_n = 0;
    host_wr_n = 0;
    repeat (4) @(negedge clk);
    host_wr_n = 1;
    @(negedge clk);
    host_cs_n = 1;
    host_data_in = ~d;
    host_addr = ~a;
  endtask

  task automatic host_rd(input logic [15:0] a, output logic [7:0] d);
    int i;
    repeat (11) @(negedge clk);
    host_addr = a;
    host_cs_n = 0;
    host_rd_n = 0;
    i = 0;
    while (host_data_oe_n !== 1'b0 && i < 8) begin
      @(negedge clk);
      i++;
    end
    check_val(i <= 7, 1);
    repeat (2) @(negedge clk);
    d = host_data_out;
    host_rd_n = 1;
    host_cs_n = 1;
    host_addr = ~a;
  endtask

  task automatic cmd(input logic [7:0] c);
    hc_en = 1;
    repeat (3) @(negedge host_clk);
    cmd_strobe = 1;
    cmd_code = c;
    @(negedge host_clk);
    cmd_strobe = 0;
    cmd_code = ~c;
    hc_en = 0;
  endtask

  task automatic wait_pd(input logic v, input int lim);
    n = 0;
    while (panel_power_down_out !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ==========================================================
  // tests
  initial begin
    int         a;
    logic [7:0] d, r;
    void'($urandom(2369));
    repeat (3) @(negedge clk);
    reset = 0;
    for (int s = 0; s < 4; s++) begin
      shift_rate_strap = s[1:0];
      repeat (200) @(negedge clk);
      check_val(period, exp_div(s));
      check_bit(shift_rate_unsupported, 200 / exp_div(s) > 15);
    end
    $display("test shift rate done");
    host_wr(16'h8009, 8'h01);
    wait_pd(1, 6);
    check_bit(panel_power_down_out, 1);
    check_bit(display_enabled, 1);
    host_rd(16'h8009, r);
    check_val(r, 8'h01);
    host_wr(16'h8009, 8'h00);
    wait_pd(0, 6);
    check_bit(panel_power_down_out, 0);
    $display("test display enable done");
    host_wr(16'h8009, 8'h01);
    wait_pd(1, 6);
    host_wr(16'h8008, 8'h01);
    wait_pd(0, 2 * 3 * 10 * 16 + 8);
    check_bit(panel_power_down_out, 0);
    check_bit(power_saving, 1);
    host_wr(16'h8008, 8'h00);
    host_wr(16'h8009, 8'h00);
    check_bit(power_saving, 0);
    $display("test power save done");
    indirect_mode = 1;
    host_wr(16'h8009, 8'h01);
    wait_pd(1, 6);
    check_bit(panel_power_down_out, 1);
    d = $urandom;
    if (d == 8'h58) d = 8'h59;
    cmd(d);
    repeat (10) @(negedge clk);
    check_bit(panel_power_down_out, 1);
    cmd(8'h58);
    wait_pd(0, 8);
    check_bit(panel_power_down_out, 0);
    check_bit(display_enabled, 0);
    indirect_mode = 0;
    host_wr(16'h8009, 8'h01);
    wait_pd(1, 6);
    cmd(8'h58);
    repeat (10) @(negedge clk);
    check_bit(panel_power_down_out, 1);
    $display("test command port done");
    for (int i = 0; i < 6; i++) begin
      a = i == 0 ? 32703 : $urandom % 32704;
      d = $urandom;
      mem_m[a] = d;
      host_wr({1'b0, a[14:0]}, d);
    end
    foreach (mem_m[k]) begin
      host_rd({1'b0, k[14:0]}, r);
      check_val(r, mem_m[k]);
    end
    d = $urandom;
    host_wr(16'h0000, d);
    repeat (1000) @(negedge clk);
    check_val(first_nibble, d[7:4]);
    $display("test memory done");
    check_bit(n_unstable == 0, 1);
    check_bit(lp_gap >= 2, 1);
    check_bit(rs_gap >= 3, 1);
    $display("test panel strobes done");
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
